// >>> shared/bt_pwr_pkg.sv
// Shared constants and types for the power handshake and link control block.
package bt_pwr_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATE = 8'h08;
    localparam logic [7:0] OFS_TEST = 8'h0C;
    localparam logic [7:0] OFS_PWR = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_SNIFF = 8'h1C;
    localparam logic [7:0] OFS_PADFN = 8'h20;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_HS_EN = 0;
    localparam int CTRL_WAKE_POL = 1;
    localparam int CTRL_ALERT_POL = 2;
    localparam int CTRL_BLE = 3;
    localparam int PWR_W = 6;
    localparam int PWR_TX = 0;
    localparam int PWR_RX = 1;
    localparam int PWR_PLL = 2;
    localparam int PWR_PA = 3;
    localparam int PWR_ALERT = 4;
    localparam int PWR_CLK = 5;
    localparam int TEST_PRBS = 3;
    localparam int TEST_PAT_LSB = 8;
    localparam int PAT_W = 8;
    localparam int ST_W = 4;
    localparam int ST_WAKE_RISE = 0;
    localparam int ST_WAKE_FALL = 1;
    localparam int ST_SNIFF_WAKE = 2;
    localparam int ST_CMD_DONE = 3;
    localparam int STATE_AWAKE = 3;
    localparam int STATE_WAKE_IN = 4;
    localparam int PADFN_W = 2;
    localparam logic [1:0] PADFN_HANDSHAKE = 2'h0;
    localparam int SNIFF_W = 16;
    localparam logic [15:0] SNIFF_RST = 16'h0100;
    localparam int PRBS_W = 9;
    localparam logic [8:0] PRBS_SEED = 9'h1FF;
    localparam int PRBS_TAP = 4;
    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LC_STANDBY = 3'h0, LC_PAGE = 3'h1, LC_PAGE_SCAN = 3'h3, LC_INQUIRY = 3'h2,
        LC_INQ_SCAN = 3'h6, LC_CONNECTION = 3'h7, LC_SNIFF = 3'h5
    } lc_state_e;
    typedef enum logic [2:0] {
        CMD_STANDBY = 3'h0, CMD_PAGE = 3'h1, CMD_PAGE_SCAN = 3'h2, CMD_INQUIRY = 3'h3,
        CMD_INQ_SCAN = 3'h4, CMD_CONNECT = 3'h5, CMD_SNIFF = 3'h6, CMD_UNSNIFF = 3'h7
    } lc_cmd_e;
    typedef enum logic [2:0] {
        TM_OFF = 3'h0, TM_TX_TEST = 3'h1, TM_LOOP = 3'h2, TM_DLOOP = 3'h3,
        TM_REDHOP = 3'h4, TM_CARRIER = 3'h5, TM_CONST_RX = 3'h6, TM_CONST_TX = 3'h7
    } test_mode_e;
endpackage

// >>> hw/wake_sync.sv
// Two-stage synchroniser with polarity correction for the host wake pin.
`timescale 1ns/100ps
module wake_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic active_high,
    output logic asserted
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_s;
    sync_s s_r;
    sync_s s_nxt;

    always_comb
    begin
        s_nxt.s1 = pin;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // Polarity is applied only after the second stage.
    assign asserted = active_high ? s_r.s2 : ~s_r.s2;
endmodule

// >>> hw/prbs9_gen.sv
// PRBS-9 source for the transmitter test and constant-transmit test modes.
`timescale 1ns/100ps
module prbs9_gen (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic step,
    output logic bit_out
);
    typedef struct packed {
        logic [bt_pwr_pkg::PRBS_W-1:0] lfsr;
    } prbs_s;
    prbs_s s_r;
    prbs_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (step)
            s_nxt.lfsr = {s_r.lfsr[bt_pwr_pkg::PRBS_W-2:0],
                          s_r.lfsr[bt_pwr_pkg::PRBS_W-1] ^ s_r.lfsr[bt_pwr_pkg::PRBS_TAP]};
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            s_r.lfsr <= bt_pwr_pkg::PRBS_SEED;
        else
            s_r <= s_nxt;
    end

    assign bit_out = s_r.lfsr[bt_pwr_pkg::PRBS_W-1];
endmodule

// >>> hw/bt_power_handshake_link_ctl.sv
// Link control, test modes, radio power-down and host wake handshake.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
//
// Contract
// - Software commands drive a command controller that steps the link controllers.
// - Standby and connection states plus page, page scan, inquiry, inquiry scan, sniff.
// - Standard test mode: transmitter test, loopback, delayed loopback, reduced hopping.
// - Carrier test sends unmodulated carrier on one frequency with hopping stopped.
// - Constant-receive test routes demodulated receive bits to an output pin.
// - Constant-transmit test sends fixed eight-bit pattern or PRBS-9.
// - Power requests come from software registers and baseband packet activity.
// - Separate power-down outputs for transmit, receive, PLL and power amplifier.
// - Sideband wake handshake with the host can be enabled by software.
// - Asserted device wake keeps the device awake; deasserted lets it sleep.
// - Host alert is asserted while the device needs host attention.
// - Device wake and host alert polarities are software selectable.
// - Reference clock request is active high when either function needs clock.
// - Handshake pins work only while the pad function setting is zero.
// - A low energy operating mode is selectable beside classic operation.
// - Sniff runs from the low-power oscillator and wakes after a set time.
module bt_power_handshake_link_ctl #(
    parameter int SNIFF_W = bt_pwr_pkg::SNIFF_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [bt_pwr_pkg::ADDR_W-1:0] addr,
    input wire logic [bt_pwr_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [bt_pwr_pkg::DATA_W-1:0] rdata,
    input wire logic device_wake_in,
    input wire logic wlan_refclk_need,
    input wire logic bb_tx_active,
    input wire logic bb_rx_active,
    input wire logic rx_demod_bit,
    output logic host_alert_out,
    output logic bluetooth_refclk_request_pin,
    output logic wireless_lan_refclk_request_pin,
    output logic tx_pd,
    output logic rx_pd,
    output logic pll_pd,
    output logic pa_pd,
    output logic tx_data_bit,
    output logic tx_modulate_en,
    output logic hop_en,
    output logic hop_reduced,
    output logic loopback_en,
    output logic ber_data_pin,
    output logic lpo_select,
    output logic ble_mode,
    output logic core_awake,
    output logic irq
);
    typedef struct packed {
        logic hs_en;
        logic wake_pol;
        logic alert_pol;
        logic ble;
        logic [bt_pwr_pkg::PADFN_W-1:0] padfn;
        bt_pwr_pkg::test_mode_e tmode;
        logic prbs_sel;
        logic [bt_pwr_pkg::PAT_W-1:0] pattern;
        logic [2:0] pat_idx;
        logic [bt_pwr_pkg::PWR_W-1:0] pwr;
        logic [bt_pwr_pkg::ST_W-1:0] sts;
        logic [bt_pwr_pkg::ST_W-1:0] mask;
        logic [SNIFF_W-1:0] sniff_ivl;
        logic [SNIFF_W-1:0] sniff_cnt;
        bt_pwr_pkg::lc_state_e state;
        logic wake_d;
        logic loop_d;
        logic [bt_pwr_pkg::DATA_W-1:0] rdata;
        logic host_alert;
        logic bt_req;
        logic wl_req;
        logic tx_pd;
        logic rx_pd;
        logic pll_pd;
        logic pa_pd;
        logic tx_bit;
        logic tx_mod;
        logic hop_en;
        logic hop_red;
        logic loop_en;
        logic ber;
        logic lpo;
        logic awake;
        logic irq;
    } ctl_s;

    ctl_s s_r;
    ctl_s s_nxt;
    logic wake_sync_lvl;
    logic prbs_bit;
    logic prbs_step;

    // ----------------------------------------------------------------
    // Host wake input and PRBS source
    // ----------------------------------------------------------------
    wake_sync u_wake_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(device_wake_in),
        .active_high(s_r.wake_pol),
        .asserted(wake_sync_lvl)
    );

    prbs9_gen u_prbs (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .step(prbs_step),
        .bit_out(prbs_bit)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic hs_act;
        logic wake_act;
        logic cmd_wr;
        logic cmd_ok;
        logic sniff_ev;
        logic pat_mode;
        logic tx_on;
        logic rx_on;
        logic asleep;
        logic fixed_freq;
        logic [bt_pwr_pkg::ST_W-1:0] ev;
        bt_pwr_pkg::lc_cmd_e cmd;
        hs_act = 1'b0;
        wake_act = 1'b0;
        cmd_wr = 1'b0;
        cmd_ok = 1'b0;
        sniff_ev = 1'b0;
        pat_mode = 1'b0;
        tx_on = 1'b0;
        rx_on = 1'b0;
        asleep = 1'b0;
        fixed_freq = 1'b0;
        ev = '0;
        cmd = bt_pwr_pkg::lc_cmd_e'(wdata[2:0]);
        s_nxt = s_r;

        hs_act = s_r.hs_en && (s_r.padfn == bt_pwr_pkg::PADFN_HANDSHAKE);
        // Without the handshake nobody can wake us, so the core never sleeps.
        wake_act = !hs_act || wake_sync_lvl;
        s_nxt.wake_d = wake_act;

        if (wr_en)
        begin
            unique case (addr)
                bt_pwr_pkg::OFS_CTRL:
                begin
                    s_nxt.hs_en = wdata[bt_pwr_pkg::CTRL_HS_EN];
                    s_nxt.wake_pol = wdata[bt_pwr_pkg::CTRL_WAKE_POL];
                    s_nxt.alert_pol = wdata[bt_pwr_pkg::CTRL_ALERT_POL];
                    s_nxt.ble = wdata[bt_pwr_pkg::CTRL_BLE];
                end
                bt_pwr_pkg::OFS_CMD: cmd_wr = 1'b1;
                bt_pwr_pkg::OFS_TEST:
                begin
                    s_nxt.tmode = bt_pwr_pkg::test_mode_e'(wdata[2:0]);
                    s_nxt.prbs_sel = wdata[bt_pwr_pkg::TEST_PRBS];
                    s_nxt.pattern = wdata[bt_pwr_pkg::TEST_PAT_LSB +: bt_pwr_pkg::PAT_W];
                end
                bt_pwr_pkg::OFS_PWR: s_nxt.pwr = wdata[bt_pwr_pkg::PWR_W-1:0];
                bt_pwr_pkg::OFS_MASK: s_nxt.mask = wdata[bt_pwr_pkg::ST_W-1:0];
                bt_pwr_pkg::OFS_SNIFF: s_nxt.sniff_ivl = wdata[SNIFF_W-1:0];
                bt_pwr_pkg::OFS_PADFN: s_nxt.padfn = wdata[bt_pwr_pkg::PADFN_W-1:0];
                default: ;
            endcase
        end

        // Command controller: a command is taken only from a state where it applies.
        if (cmd_wr)
        begin
            unique case (cmd)
                bt_pwr_pkg::CMD_STANDBY: cmd_ok = 1'b1;
                bt_pwr_pkg::CMD_PAGE, bt_pwr_pkg::CMD_PAGE_SCAN,
                bt_pwr_pkg::CMD_INQUIRY, bt_pwr_pkg::CMD_INQ_SCAN:
                    cmd_ok = (s_r.state == bt_pwr_pkg::LC_STANDBY);
                bt_pwr_pkg::CMD_CONNECT:
                    cmd_ok = (s_r.state == bt_pwr_pkg::LC_PAGE) || (s_r.state == bt_pwr_pkg::LC_PAGE_SCAN);
                bt_pwr_pkg::CMD_SNIFF: cmd_ok = (s_r.state == bt_pwr_pkg::LC_CONNECTION);
                bt_pwr_pkg::CMD_UNSNIFF: cmd_ok = (s_r.state == bt_pwr_pkg::LC_SNIFF);
            endcase
        end

        if (cmd_ok)
        begin
            unique case (cmd)
                bt_pwr_pkg::CMD_STANDBY: s_nxt.state = bt_pwr_pkg::LC_STANDBY;
                bt_pwr_pkg::CMD_PAGE: s_nxt.state = bt_pwr_pkg::LC_PAGE;
                bt_pwr_pkg::CMD_PAGE_SCAN: s_nxt.state = bt_pwr_pkg::LC_PAGE_SCAN;
                bt_pwr_pkg::CMD_INQUIRY: s_nxt.state = bt_pwr_pkg::LC_INQUIRY;
                bt_pwr_pkg::CMD_INQ_SCAN: s_nxt.state = bt_pwr_pkg::LC_INQ_SCAN;
                bt_pwr_pkg::CMD_CONNECT: s_nxt.state = bt_pwr_pkg::LC_CONNECTION;
                bt_pwr_pkg::CMD_SNIFF:
                begin
                    s_nxt.state = bt_pwr_pkg::LC_SNIFF;
                    // A zero interval is loaded as one and, like one, expires after one cycle.
                    s_nxt.sniff_cnt = (s_r.sniff_ivl == '0) ? SNIFF_W'(1) : s_r.sniff_ivl;
                end
                bt_pwr_pkg::CMD_UNSNIFF: s_nxt.state = bt_pwr_pkg::LC_CONNECTION;
            endcase
        end
        else if (s_r.state == bt_pwr_pkg::LC_SNIFF)
        begin
            if (s_r.sniff_cnt <= SNIFF_W'(1))
            begin
                s_nxt.state = bt_pwr_pkg::LC_CONNECTION;
                s_nxt.sniff_cnt = '0;
                sniff_ev = 1'b1;
            end
            else
                s_nxt.sniff_cnt = s_r.sniff_cnt - SNIFF_W'(1);
        end

        // ------------------------------------------------------------
        // Test modes
        // ------------------------------------------------------------
        fixed_freq = (s_r.tmode == bt_pwr_pkg::TM_CARRIER) || (s_r.tmode == bt_pwr_pkg::TM_CONST_RX)
            || (s_r.tmode == bt_pwr_pkg::TM_CONST_TX);
        pat_mode = (s_r.tmode == bt_pwr_pkg::TM_CONST_TX) || (s_r.tmode == bt_pwr_pkg::TM_TX_TEST);
        s_nxt.hop_en = !fixed_freq;
        s_nxt.hop_red = (s_r.tmode == bt_pwr_pkg::TM_REDHOP);
        s_nxt.loop_en = (s_r.tmode == bt_pwr_pkg::TM_LOOP) || (s_r.tmode == bt_pwr_pkg::TM_DLOOP);
        s_nxt.ber = (s_r.tmode == bt_pwr_pkg::TM_CONST_RX) && rx_demod_bit;
        s_nxt.loop_d = rx_demod_bit;
        s_nxt.pat_idx = pat_mode ? s_r.pat_idx + 3'h1 : 3'h0;
        s_nxt.tx_mod = (s_r.tmode != bt_pwr_pkg::TM_CARRIER)
            && (pat_mode || s_nxt.loop_en || bb_tx_active);
        unique case (s_r.tmode)
            bt_pwr_pkg::TM_TX_TEST, bt_pwr_pkg::TM_CONST_TX:
                s_nxt.tx_bit = s_r.prbs_sel ? prbs_bit : s_r.pattern[s_r.pat_idx];
            bt_pwr_pkg::TM_LOOP: s_nxt.tx_bit = rx_demod_bit;
            bt_pwr_pkg::TM_DLOOP: s_nxt.tx_bit = s_r.loop_d;
            default: s_nxt.tx_bit = 1'b0;
        endcase

        // ------------------------------------------------------------
        // Radio power-down and sleep
        // ------------------------------------------------------------
        tx_on = bb_tx_active || (s_r.tmode == bt_pwr_pkg::TM_CARRIER) || pat_mode || s_nxt.loop_en
            || (s_r.tmode == bt_pwr_pkg::TM_REDHOP);
        rx_on = bb_rx_active || s_nxt.loop_en || (s_r.tmode == bt_pwr_pkg::TM_CONST_RX);
        asleep = !wake_act && (s_r.state == bt_pwr_pkg::LC_STANDBY) && !tx_on && !rx_on
            && !s_r.pwr[bt_pwr_pkg::PWR_ALERT];
        s_nxt.awake = !asleep;
        s_nxt.tx_pd = s_r.pwr[bt_pwr_pkg::PWR_TX] || !tx_on || asleep;
        s_nxt.pa_pd = s_r.pwr[bt_pwr_pkg::PWR_PA] || !tx_on || asleep;
        s_nxt.rx_pd = s_r.pwr[bt_pwr_pkg::PWR_RX] || !rx_on || asleep;
        s_nxt.pll_pd = s_r.pwr[bt_pwr_pkg::PWR_PLL] || !(tx_on || rx_on) || asleep;
        s_nxt.lpo = (s_nxt.state == bt_pwr_pkg::LC_SNIFF);

        // ------------------------------------------------------------
        // Events, interrupt and handshake outputs
        // ------------------------------------------------------------
        ev[bt_pwr_pkg::ST_WAKE_RISE] = wake_act && !s_r.wake_d;
        ev[bt_pwr_pkg::ST_WAKE_FALL] = !wake_act && s_r.wake_d;
        ev[bt_pwr_pkg::ST_SNIFF_WAKE] = sniff_ev;
        ev[bt_pwr_pkg::ST_CMD_DONE] = cmd_ok;
        // A new event in the reading cycle survives the clear.
        s_nxt.sts = ((rd_en && addr == bt_pwr_pkg::OFS_STATUS) ? '0 : s_r.sts) | ev;
        s_nxt.irq = |(s_nxt.sts & s_nxt.mask);
        s_nxt.host_alert = (hs_act && (s_r.pwr[bt_pwr_pkg::PWR_ALERT] || s_nxt.irq))
            ~^ s_r.alert_pol;
        s_nxt.bt_req = (s_r.padfn == bt_pwr_pkg::PADFN_HANDSHAKE)
            && (s_nxt.awake || s_r.pwr[bt_pwr_pkg::PWR_CLK] || wlan_refclk_need);
        s_nxt.wl_req = s_nxt.bt_req;

        s_nxt.rdata = '0;
        if (rd_en)
        begin
            unique case (addr)
                bt_pwr_pkg::OFS_CTRL: s_nxt.rdata = 32'({s_r.ble, s_r.alert_pol, s_r.wake_pol, s_r.hs_en});
                bt_pwr_pkg::OFS_STATE:
                    s_nxt.rdata = 32'({wake_act, s_r.awake, s_r.state});
                bt_pwr_pkg::OFS_TEST: s_nxt.rdata = 32'({s_r.pattern, 4'h0, s_r.prbs_sel, s_r.tmode});
                bt_pwr_pkg::OFS_PWR: s_nxt.rdata = 32'(s_r.pwr);
                bt_pwr_pkg::OFS_STATUS: s_nxt.rdata = 32'(s_r.sts);
                bt_pwr_pkg::OFS_MASK: s_nxt.rdata = 32'(s_r.mask);
                bt_pwr_pkg::OFS_SNIFF: s_nxt.rdata = 32'(s_r.sniff_ivl);
                bt_pwr_pkg::OFS_PADFN: s_nxt.rdata = 32'(s_r.padfn);
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    assign prbs_step = s_r.prbs_sel && ((s_r.tmode == bt_pwr_pkg::TM_CONST_TX)
        || (s_r.tmode == bt_pwr_pkg::TM_TX_TEST));

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.wake_pol <= 1'b1;
            s_r.alert_pol <= 1'b1;
            s_r.sniff_ivl <= SNIFF_W'(bt_pwr_pkg::SNIFF_RST);
            s_r.tx_pd <= 1'b1;
            s_r.rx_pd <= 1'b1;
            s_r.pll_pd <= 1'b1;
            s_r.pa_pd <= 1'b1;
            s_r.hop_en <= 1'b1;
            s_r.awake <= 1'b1;
            // The wake level idles high while the handshake is off, so no false rise follows reset.
            s_r.wake_d <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign rdata = s_r.rdata;
    assign host_alert_out = s_r.host_alert;
    assign bluetooth_refclk_request_pin = s_r.bt_req;
    assign wireless_lan_refclk_request_pin = s_r.wl_req;
    assign tx_pd = s_r.tx_pd;
    assign rx_pd = s_r.rx_pd;
    assign pll_pd = s_r.pll_pd;
    assign pa_pd = s_r.pa_pd;
    assign tx_data_bit = s_r.tx_bit;
    assign tx_modulate_en = s_r.tx_mod;
    assign hop_en = s_r.hop_en;
    assign hop_reduced = s_r.hop_red;
    assign loopback_en = s_r.loop_en;
    assign ber_data_pin = s_r.ber;
    assign lpo_select = s_r.lpo;
    assign ble_mode = s_r.ble;
    assign core_awake = s_r.awake;
    assign irq = s_r.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_page_cmd;
        wr_en && addr == bt_pwr_pkg::OFS_CMD && wdata[2:0] == bt_pwr_pkg::CMD_PAGE
            && s_r.state == bt_pwr_pkg::LC_STANDBY;
    endsequence

    sequence s_wake_held;
        (device_wake_in && s_r.wake_pol && s_r.hs_en && s_r.padfn == bt_pwr_pkg::PADFN_HANDSHAKE)[*4];
    endsequence

    a_cmd_page: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_page_cmd |=> s_r.state == bt_pwr_pkg::LC_PAGE ##0 s_r.sts[bt_pwr_pkg::ST_CMD_DONE])
        else $error("page command not taken");

    a_state_legal: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_r.state inside {bt_pwr_pkg::LC_STANDBY, bt_pwr_pkg::LC_PAGE, bt_pwr_pkg::LC_PAGE_SCAN,
            bt_pwr_pkg::LC_INQUIRY, bt_pwr_pkg::LC_INQ_SCAN, bt_pwr_pkg::LC_CONNECTION, bt_pwr_pkg::LC_SNIFF})
        else $error("illegal link state");

    a_carrier_nohop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_r.tmode == bt_pwr_pkg::TM_CARRIER |=> !hop_en && !tx_modulate_en)
        else $error("carrier test hops or modulates");

    a_ber_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_r.tmode == bt_pwr_pkg::TM_CONST_RX |=> ber_data_pin == $past(rx_demod_bit))
        else $error("receive bit not routed");

    a_pattern_tx: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_r.tmode == bt_pwr_pkg::TM_CONST_TX && !s_r.prbs_sel
            |=> tx_data_bit == $past(s_r.pattern[s_r.pat_idx]) && tx_modulate_en)
        else $error("fixed pattern not sent");

    a_pd_tx_pkt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bb_tx_active && !s_r.pwr[bt_pwr_pkg::PWR_TX] && !s_r.pwr[bt_pwr_pkg::PWR_PLL] |=> !tx_pd && !pll_pd)
        else $error("transmit path held down during packet");

    a_wake_awake: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_wake_held |=> core_awake)
        else $error("device slept while wake asserted");

    a_alert_pol: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !s_r.hs_en |=> host_alert_out == !$past(s_r.alert_pol))
        else $error("alert idle level wrong");

    a_refclk_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wlan_refclk_need && s_r.padfn == bt_pwr_pkg::PADFN_HANDSHAKE
            |=> bluetooth_refclk_request_pin && wireless_lan_refclk_request_pin)
        else $error("clock request missing");

    a_sniff_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_r.state == bt_pwr_pkg::LC_SNIFF && s_r.sniff_cnt == SNIFF_W'(1) && !wr_en
            |=> s_r.state == bt_pwr_pkg::LC_CONNECTION && !lpo_select)
        else $error("sniff did not wake on time");
endmodule

// >>> sim/host_wake_model.sv
// Host side model that drives the device wake pin.
`timescale 1ns/100ps
module host_wake_model (
    input wire logic ref_clk,
    input wire logic want_device,
    input wire logic active_high,
    output logic device_wake_in
);
    initial device_wake_in = 1'b0;
    // The host moves the pin just after a ref_clk edge, as a flop on that same clock would.
    always @(posedge ref_clk)
    begin
        device_wake_in <= want_device ~^ active_high;
    end
endmodule

// >>> sim/bt_power_handshake_link_ctl_bench.sv
// Self-checking bench for the power handshake and link control block.
`timescale 1ns/100ps
module bt_power_handshake_link_ctl_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic wr_en = 1'b0, rd_en = 1'b0, wlan_need = 1'b0, tx_act = 1'b0, rx_act = 1'b0, rx_bit = 1'b0;
    logic want = 1'b0, pol = 1'b1, wake, alert, bt_req, wl_req, tx_pd, rx_pd, pll_pd, pa_pd, hop_en, hop_red;
    logic loop_en, mod_en, ber, lpo, awake, irq, tx_bit, ble;
    logic [8:0] ps;
    logic [15:0] rnd = 16'hEA80;
    logic [31:0] cmds [10] = '{32'h2, 32'h0, 32'h3, 32'h0, 32'h4, 32'h0, 32'h1, 32'h5, 32'h1, 32'h6};
    logic [2:0] exp_st [10] = '{3'h3, 3'h0, 3'h2, 3'h0, 3'h6, 3'h0, 3'h1, 3'h7, 3'h7, 3'h5};
    int n_fail = 0, compares = 0, cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    bt_power_handshake_link_ctl #(.SNIFF_W(16)) u_bt_power_handshake_link_ctl (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .device_wake_in(wake),
        .wlan_refclk_need(wlan_need), .bb_tx_active(tx_act), .bb_rx_active(rx_act), .rx_demod_bit(rx_bit),
        .host_alert_out(alert), .bluetooth_refclk_request_pin(bt_req), .wireless_lan_refclk_request_pin(wl_req),
        .tx_pd(tx_pd), .rx_pd(rx_pd), .pll_pd(pll_pd), .pa_pd(pa_pd), .tx_data_bit(tx_bit), .tx_modulate_en(mod_en),
        .hop_en(hop_en), .hop_reduced(hop_red), .loopback_en(loop_en), .ber_data_pin(ber), .lpo_select(lpo),
        .ble_mode(ble), .core_awake(awake), .irq(irq));
    host_wake_model u_host_wake_model (.ref_clk(ref_clk), .want_device(want), .active_high(pol), .device_wake_in(wake));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Reference sequence for x^9 + x^5 + 1, oldest bit out first.
    function automatic logic [8:0] prbs_nx(input logic [8:0] s);
        return {s[7:0], s[8] ^ s[4]};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic conclude;
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Generous ceiling; the whole sequence needs well under a thousand cycles.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_fail++;
            conclude();
        end
    end
    initial
    begin
        tick(3);
        rst_n <= 1'b1;
        rd(8'h00); chk("ctrl", v, 32'h6);
        rd(8'h1C); chk("sniff", v, 32'h100);
        rd(8'hFC); chk("unmapped", v, 32'h0);
        for (int p = 1; p >= 0; p--)
        begin
            pol <= p[0];
            wr(8'h00, {29'h0, p[0], p[0], 1'b1});
            wr(8'h18, 32'h1);
            tick(6);
            rd(8'h14);
            tick(2);
            chk("asleep", {bt_req, wl_req, awake, irq, alert}, {4'h0, ~p[0]});
            want <= 1'b1;
            tick(6);
            chk("awake", {bt_req, wl_req, awake, irq, alert}, {4'hF, p[0]});
            rd(8'h14); chk("status", v, 32'h1);
            tick(2); chk("irq clear", irq, 1'b0);
            want <= 1'b0;
        end
        tick(6);
        wlan_need <= 1'b1;
        tick(3); chk("wlan req", {bt_req, wl_req}, 2'h3);
        wr(8'h20, 32'h1);
        tick(3); chk("padfn req", {bt_req, wl_req}, 2'h0);
        wr(8'h20, 32'h0);
        wlan_need <= 1'b0;
        wr(8'h00, 32'h6);
        wr(8'h1C, 32'd20);
        for (int i = 0; i < 10; i++)
        begin
            wr(8'h04, cmds[i]);
            rd(8'h08); chk("state", v[2:0], exp_st[i]);
        end
        chk("lpo on", lpo, 1'b1);
        tick(30);
        rd(8'h08); chk("sniff exit", {lpo, v[2:0]}, 4'h7);
        rd(8'h14); chk("status bits", v[3:2], 2'h3);
        for (int m = 0; m < 8; m++)
        begin
            wr(8'h0C, 32'(m));
            tick(2);
            chk("loopback", {loop_en, hop_red}, {m == 2 || m == 3, m == 4});
            if (m == 5)
                chk("carrier", {hop_en, mod_en}, 2'h0);
            if (m == 6)
                repeat (8)
                begin
                    rnd = lfsr(rnd);
                    @(posedge ref_clk);
                    rx_bit <= rnd[0];
                    tick(1); chk("ber", ber, rnd[0]);
                end
        end
        wr(8'h0C, 32'h0);
        wr(8'h0C, 32'hA507);
        for (int k = 0; k < 8; k++)
        begin
            tick(1); chk("pattern", tx_bit, (8'hA5 >> k) & 8'h01);
        end
        wr(8'h0C, 32'hF);
        ps = bt_pwr_pkg::PRBS_SEED;
        repeat (20)
        begin
            tick(1); chk("prbs", tx_bit, ps[8]);
            ps = prbs_nx(ps);
        end
        wr(8'h0C, 32'h0);
        wr(8'h10, 32'hF);
        tick(2); chk("forced pd", {tx_pd, rx_pd, pll_pd, pa_pd}, 4'hF);
        wr(8'h10, 32'h0);
        repeat (4)
        begin
            rnd = lfsr(rnd);
            tx_act <= rnd[0];
            rx_act <= rnd[1];
            tick(3); chk("packet pd", {tx_pd, rx_pd}, {~rnd[0], ~rnd[1]});
        end
        wr(8'h00, 32'h8);
        tick(2); chk("ble", ble, 1'b1);
        conclude();
    end
endmodule
